//--- hw/scmi_xport.sv
// device end of the queue-based message transport
// Contract
// [RULE_01] offer platform-to-agent feature when events possible
// [RULE_02] offer statistics feature when regions possible
// [RULE_03] event queue exists only when feature negotiated
// [RULE_04] command queue carries commands and plain responses
// [RULE_05] response reuses command buffer, then marked used
// [RULE_06] command is le32 header then parameters
// [RULE_07] response is le32 header then return values
// [RULE_08] commands may complete out of order
// [RULE_09] every available command eventually completes
// [RULE_10] failed status shrinks return values to status
// [RULE_11] event requests succeed despite few event buffers
// [RULE_12] without feature, event requests get not-supported
// [RULE_13] without feature, attributes report no events
// [RULE_14] driver waits for prerequisite responses
// [RULE_15] driver supplies enough writable space
// [RULE_16] driver never requests events without feature
// [RULE_17] driver fills event queue, writable only
// [RULE_18] driver posts event buffers large enough
// [RULE_19] one event message per buffer, le32 header first
// [RULE_20] notification without buffer dropped
// [RULE_21] notification too large for buffer omitted
// [RULE_22] delayed response held; failure shrinks payload
`timescale 1ns/100ps
`default_nettype none
module scmi_xport #(
  parameter logic [31:0] P2A_ATTR_MASK = scmi_xport_pkg::P2A_ATTR_MASK_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic can_p2a,
  input wire logic can_shm,
  output logic [scmi_xport_pkg::FEAT_W-1:0] offered_features,
  input wire logic [scmi_xport_pkg::FEAT_W-1:0] drv_features,
  input wire logic features_ok,
  output logic p2a_negotiated,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire scmi_xport_pkg::cmd_t cmd,
  output logic plat_valid,
  input wire logic plat_ready,
  output scmi_xport_pkg::cmd_t plat_cmd,
  input wire logic result_valid,
  output logic result_ready,
  input wire scmi_xport_pkg::result_t result,
  output logic used_valid,
  input wire logic used_ready,
  output scmi_xport_pkg::used_t used,
  input wire logic evbuf_valid,
  output logic evbuf_ready,
  input wire scmi_xport_pkg::evbuf_t evbuf,
  input wire logic evt_valid,
  output logic evt_ready,
  input wire scmi_xport_pkg::evmsg_t evt,
  output logic evused_valid,
  input wire logic evused_ready,
  output scmi_xport_pkg::used_t evused,
  output logic notif_dropped
);
  logic [scmi_xport_pkg::FEAT_W-1:0] offered_r;
  logic p2a_neg_r;
  logic req_v_r;
  scmi_xport_pkg::cmd_t req_r;
  logic evb_have_r;
  scmi_xport_pkg::evbuf_t evb_r;
  logic drop_r;

  // feature offer follows capability levels
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      offered_r <= '0;
    end else begin
      offered_r[scmi_xport_pkg::FEAT_P2A_BIT] <= can_p2a; // see [RULE_01]
      offered_r[scmi_xport_pkg::FEAT_SHM_BIT] <= can_shm; // see [RULE_02]
    end
  end
  assign offered_features = offered_r;

  // negotiated result latched when the driver accepts features
  wire p2a_agreed = drv_features[scmi_xport_pkg::FEAT_P2A_BIT] &&
    offered_r[scmi_xport_pkg::FEAT_P2A_BIT];
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      p2a_neg_r <= 1'h0;
    end else if (features_ok) begin
      p2a_neg_r <= p2a_agreed;
    end
  end
  assign p2a_negotiated = p2a_neg_r;

  // command stage: header and parameters forwarded as read
  wire cmd_take = cmd_valid && cmd_ready;
  assign cmd_ready = !req_v_r || plat_ready; // see [RULE_09]
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_v_r <= 1'h0;
    end else if (cmd_ready) begin
      req_v_r <= cmd_valid;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (cmd_take) req_r <= cmd; // see [RULE_06]
  end
  assign plat_valid = req_v_r;
  assign plat_cmd = req_r;

  // response build; results may arrive in any order, keyed by buffer
  wire used_in_ready;
  wire result_take = result_valid && result_ready;
  wire refuse = result.p2a_req && !p2a_neg_r; // see [RULE_12]
  wire hide_attr = result.attr_query && !p2a_neg_r;
  wire [31:0] rsp_status = refuse ? scmi_xport_pkg::STATUS_NOT_SUPPORTED :
    result.status; // see [RULE_11]
  wire rsp_ok = (rsp_status == scmi_xport_pkg::STATUS_SUCCESS);
  wire [scmi_xport_pkg::LEN_W-1:0] rsp_vals = rsp_ok ? result.ret_len :
    scmi_xport_pkg::STATUS_BYTES; // see [RULE_10]
  wire [31:0] attr_word = hide_attr ? (result.ret_word & ~P2A_ATTR_MASK) :
    result.ret_word; // see [RULE_13]
  wire [31:0] rsp_word = rsp_ok ? attr_word : rsp_status;
  scmi_xport_pkg::used_t used_in;
  assign used_in.qidx = scmi_xport_pkg::QIDX_CMD; // see [RULE_04]
  assign used_in.buf_id = result.buf_id; // see [RULE_05]
  assign used_in.hdr = result.hdr; // see [RULE_07]
  assign used_in.status = rsp_status;
  assign used_in.len = scmi_xport_pkg::HDR_BYTES + rsp_vals;
  assign used_in.word = rsp_word;
  assign result_ready = used_in_ready; // see [RULE_08]

  pair_buffer #(.W($bits(scmi_xport_pkg::used_t))) u_used_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(result_valid),
    .in_ready(used_in_ready),
    .in_data(used_in),
    .out_valid(used_valid),
    .out_ready(used_ready),
    .out_data(used)
  );

  // event buffer holder; queue only open once negotiated
  wire ev_in_ready;
  wire evb_take = evbuf_valid && evbuf_ready;
  assign evbuf_ready = p2a_neg_r && !evb_have_r; // see [RULE_03]

  wire ev_ok = (evt.status == scmi_xport_pkg::STATUS_SUCCESS);
  wire [scmi_xport_pkg::LEN_W-1:0] ev_pay = ev_ok ? evt.payload_len :
    scmi_xport_pkg::STATUS_BYTES; // see [RULE_22]
  wire [scmi_xport_pkg::LEN_W-1:0] ev_need = scmi_xport_pkg::HDR_BYTES +
    ev_pay;
  wire ev_fits = (ev_need <= evb_r.size);
  wire ev_send = evt_valid && p2a_neg_r && evb_have_r && ev_in_ready &&
    (evt.delayed || ev_fits);
  wire ev_drop_none = evt_valid && !evt.delayed && !evb_have_r; // see [RULE_20]
  wire ev_drop_big = evt_valid && !evt.delayed && evb_have_r &&
    !ev_fits; // see [RULE_21]
  wire ev_drop = ev_drop_none || ev_drop_big || (evt_valid && !p2a_neg_r);
  assign evt_ready = ev_send || ev_drop; // see [RULE_22]

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      evb_have_r <= 1'h0;
      drop_r <= 1'h0;
    end else begin
      drop_r <= ev_drop && !evt.delayed;
      if (evb_take) evb_have_r <= 1'h1;
      else if (ev_send) evb_have_r <= 1'h0; // see [RULE_19]
    end
  end
  always_ff @(posedge ref_clk) begin
    if (evb_take) evb_r <= evbuf;
  end
  assign notif_dropped = drop_r;

  scmi_xport_pkg::used_t ev_in;
  assign ev_in.qidx = scmi_xport_pkg::QIDX_EVT;
  assign ev_in.buf_id = evb_r.buf_id;
  assign ev_in.hdr = evt.hdr; // see [RULE_19]
  assign ev_in.status = evt.status;
  assign ev_in.len = ev_need;
  assign ev_in.word = ev_ok ? evt.word : evt.status;

  pair_buffer #(.W($bits(scmi_xport_pkg::used_t))) u_ev_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(ev_send),
    .in_ready(ev_in_ready),
    .in_data(ev_in),
    .out_valid(evused_valid),
    .out_ready(evused_ready),
    .out_data(evused)
  );

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_result_in;
    result_valid && result_ready && !used_valid;
  endsequence
  sequence s_used_out(logic [scmi_xport_pkg::BUF_ID_W-1:0] id);
    used_valid && used.buf_id == id;
  endsequence
  sequence s_ok_in;
    result_valid && result_ready && !used_valid && p2a_negotiated &&
      result.status == scmi_xport_pkg::STATUS_SUCCESS;
  endsequence
  sequence s_ev_in;
    ev_send && !evused_valid;
  endsequence
  sequence s_used_stall;
    used_valid && !used_ready;
  endsequence

  chk_offer_p2a: assert property ( // see [RULE_01]
    can_p2a ##1 can_p2a |-> offered_features[scmi_xport_pkg::FEAT_P2A_BIT])
    else $error("platform-to-agent feature not offered");

  chk_offer_shm: assert property ( // see [RULE_02]
    !can_shm ##1 !can_shm |->
      !offered_features[scmi_xport_pkg::FEAT_SHM_BIT])
    else $error("statistics feature offered without capability");

  chk_evq_gate: assert property ( // see [RULE_03]
    evused_valid || evbuf_ready |-> p2a_negotiated)
    else $error("event queue used without negotiation");

  chk_queue_index: assert property ( // see [RULE_04]
    used_valid |-> used.qidx == scmi_xport_pkg::QIDX_CMD)
    else $error("command response on wrong queue");

  chk_same_buffer: assert property ( // see [RULE_05]
    s_result_in |=> s_used_out($past(result.buf_id)))
    else $error("response not returned in command buffer");

  chk_cmd_forward: assert property ( // see [RULE_09]
    cmd_valid && cmd_ready |=> plat_valid && plat_cmd == $past(cmd))
    else $error("command not forwarded");

  chk_status_shrink: assert property ( // see [RULE_10]
    used_valid && used.status != scmi_xport_pkg::STATUS_SUCCESS |->
      used.len == scmi_xport_pkg::HDR_BYTES + scmi_xport_pkg::STATUS_BYTES)
    else $error("failed response not shrunk");

  chk_refuse_p2a: assert property ( // see [RULE_12]
    result_valid && result_ready && !used_valid && result.p2a_req &&
      !p2a_negotiated |=>
      used.status == scmi_xport_pkg::STATUS_NOT_SUPPORTED)
    else $error("event request not refused");

  chk_attr_hidden: assert property ( // see [RULE_13]
    result_valid && result_ready && !used_valid && result.attr_query &&
      !result.p2a_req && !p2a_negotiated &&
      result.status == scmi_xport_pkg::STATUS_SUCCESS |=>
      (used.word & P2A_ATTR_MASK) == 32'h00000000)
    else $error("event attributes shown without negotiation");

  chk_notif_drop: assert property ( // see [RULE_20]
    evt_valid && !evt.delayed && !evb_have_r |=> notif_dropped)
    else $error("notification without buffer not dropped");

  chk_delay_held: assert property ( // see [RULE_22]
    evt_valid && evt.delayed && p2a_negotiated && !evb_have_r |->
      !evt_ready)
    else $error("delayed response lost without buffer");

  chk_used_hold: assert property ( // see [RULE_05]
    s_used_stall |=> used_valid && $stable(used))
    else $error("used record changed while stalled");

  chk_evused_hold: assert property ( // see [RULE_19]
    evused_valid && !evused_ready |=> evused_valid && $stable(evused))
    else $error("event record changed while stalled");

  chk_plat_hold: assert property ( // see [RULE_09]
    plat_valid && !plat_ready |=> plat_valid && $stable(plat_cmd))
    else $error("command to handler changed while stalled");

  chk_cmd_block: assert property ( // see [RULE_09]
    plat_valid && !plat_ready |-> !cmd_ready)
    else $error("command taken while handler stalled");

  chk_cmd_open: assert property ( // see [RULE_09]
    !plat_valid |-> cmd_ready)
    else $error("command refused while stage empty");

  chk_result_room: assert property ( // see [RULE_09]
    !used_valid |-> result_ready)
    else $error("result refused while buffer empty");

  chk_resp_header: assert property ( // see [RULE_07]
    s_result_in |=> used_valid && used.hdr == $past(result.hdr))
    else $error("response header not kept");

  chk_success_kept: assert property ( // see [RULE_11]
    s_ok_in |=> used.status == scmi_xport_pkg::STATUS_SUCCESS)
    else $error("successful status altered");

  chk_full_len: assert property ( // see [RULE_07]
    s_ok_in |=>
      used.len == scmi_xport_pkg::HDR_BYTES + $past(result.ret_len))
    else $error("response length not header plus values");

  chk_evt_queue: assert property ( // see [RULE_19]
    evused_valid |-> evused.qidx == scmi_xport_pkg::QIDX_EVT)
    else $error("event record on wrong queue");

  chk_evt_header: assert property ( // see [RULE_19]
    s_ev_in |=> evused_valid && evused.hdr == $past(evt.hdr) &&
      evused.buf_id == $past(evb_r.buf_id))
    else $error("event not written to the held buffer");

  chk_evt_shrink: assert property ( // see [RULE_22]
    evused_valid && evused.status != scmi_xport_pkg::STATUS_SUCCESS |->
      evused.len == scmi_xport_pkg::HDR_BYTES + scmi_xport_pkg::STATUS_BYTES)
    else $error("failed delayed response not shrunk");

  chk_big_drop: assert property ( // see [RULE_21]
    evt_valid && !evt.delayed && evb_have_r && !ev_fits |=>
      notif_dropped && evb_have_r)
    else $error("oversized notification not dropped");

  chk_notif_ready: assert property ( // see [RULE_20]
    evt_valid && !evt.delayed && !evb_have_r |-> evt_ready)
    else $error("notification stalled without buffer");

  chk_delay_sent: assert property ( // see [RULE_22]
    evt_valid && evt.delayed && p2a_negotiated && evb_have_r &&
      ev_in_ready |-> evt_ready)
    else $error("held delayed response not sent");

  chk_neg_latch: assert property ( // see [RULE_03]
    features_ok |=> p2a_negotiated ==
      $past(drv_features[scmi_xport_pkg::FEAT_P2A_BIT] &&
      offered_features[scmi_xport_pkg::FEAT_P2A_BIT]))
    else $error("negotiation result not latched");

  chk_neg_hold: assert property ( // see [RULE_03]
    !features_ok |=> $stable(p2a_negotiated))
    else $error("negotiation changed without request");

  chk_drop_pulse: assert property ( // see [RULE_20]
    notif_dropped |-> $past(evt_valid && evt_ready && !evt.delayed))
    else $error("drop flagged without a taken notification");
endmodule : scmi_xport
`default_nettype wire

//--- hw/scmi_xport_pkg.sv
// shared constants and carrier types for the message transport
package scmi_xport_pkg;
  localparam int BUF_ID_W = 8;
  localparam int LEN_W = 12;
  localparam int FEAT_W = 2;
  localparam int FEAT_P2A_BIT = 0;
  localparam int FEAT_SHM_BIT = 1;
  localparam logic QIDX_CMD = 1'h0;
  localparam logic QIDX_EVT = 1'h1;
  localparam logic [LEN_W-1:0] HDR_BYTES = 12'h004;
  localparam logic [LEN_W-1:0] STATUS_BYTES = 12'h004;
  localparam logic [31:0] STATUS_SUCCESS = 32'h00000000;
  localparam logic [31:0] STATUS_NOT_SUPPORTED = 32'hFFFFFFFF;
  localparam logic [31:0] P2A_ATTR_MASK_DEF = 32'hFFFFFFFF;

  // command as taken from the command queue; hdr is le32, byte 0 in [7:0]
  typedef struct packed {
    logic [BUF_ID_W-1:0] buf_id;
    logic [31:0] hdr;
    logic [LEN_W-1:0] params_len;
  } cmd_t;

  // result handed back by the command handler
  typedef struct packed {
    logic [BUF_ID_W-1:0] buf_id;
    logic [31:0] hdr;
    logic [31:0] status;
    logic [LEN_W-1:0] ret_len;
    logic [31:0] ret_word;
    logic p2a_req;
    logic attr_query;
  } result_t;

  // used-buffer record: total bytes written, header, status, first word
  typedef struct packed {
    logic qidx;
    logic [BUF_ID_W-1:0] buf_id;
    logic [31:0] hdr;
    logic [31:0] status;
    logic [LEN_W-1:0] len;
    logic [31:0] word;
  } used_t;

  // device-writable event buffer posted by the driver
  typedef struct packed {
    logic [BUF_ID_W-1:0] buf_id;
    logic [LEN_W-1:0] size;
  } evbuf_t;

  // notification or delayed response from the platform
  typedef struct packed {
    logic delayed;
    logic [31:0] hdr;
    logic [31:0] status;
    logic [LEN_W-1:0] payload_len;
    logic [31:0] word;
  } evmsg_t;
endpackage : scmi_xport_pkg

//--- hw/pair_buffer.sv
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module pair_buffer #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_r [2];
  logic wr_r;
  logic rd_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_r <= 1'h0;
      rd_r <= 1'h0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wr_r <= ~wr_r;
      if (pop) rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'h0, push} - {1'h0, pop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem_r[wr_r] <= in_data;
  end
endmodule : pair_buffer
`default_nettype wire

//--- verification/evq_drv_model.sv
// driver-side model that posts event buffers and takes used ones
`timescale 1ns/100ps
`default_nettype none
module evq_drv_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic post,
  input wire logic [7:0] post_id,
  input wire logic stall,
  output logic evbuf_valid,
  input wire logic evbuf_ready,
  output scmi_xport_pkg::evbuf_t evbuf,
  output logic evused_ready
);
  assign evused_ready = !stall;
  // writable buffers of one fixed size
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      evbuf_valid <= 1'b0;
      evbuf <= '0;
    end else if (evbuf_valid && evbuf_ready) begin
      evbuf_valid <= 1'b0;
      evbuf <= ~evbuf;
    end else if (post && !evbuf_valid) begin
      evbuf_valid <= 1'b1;
      evbuf <= {post_id, 12'h008};
    end
  end
endmodule : evq_drv_model
`default_nettype wire

//--- verification/scmi_xport_tb.sv
// self-checking bench for the message transport
`timescale 1ns/100ps
`default_nettype none
module scmi_xport_tb;
  localparam logic [31:0] MASK = 32'h000000FF;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic can_p2a = 1'b0, can_shm = 1'b0, features_ok = 1'b0;
  logic [1:0] drv_features = 2'h0;
  logic cmd_valid = 1'b0, plat_ready = 1'b0, result_valid = 1'b0;
  logic used_ready = 1'b0, evt_valid = 1'b0, post = 1'b0, stall = 1'b0;
  logic [7:0] post_id = 8'h00;
  logic neg = 1'b0;
  scmi_xport_pkg::cmd_t cmd = '0;
  scmi_xport_pkg::result_t result = '0;
  scmi_xport_pkg::evmsg_t evt = '0;
  logic [1:0] offered_features;
  logic p2a_negotiated, cmd_ready, plat_valid, result_ready, used_valid;
  logic evbuf_valid, evbuf_ready, evt_ready, evused_valid, evused_ready;
  logic notif_dropped;
  scmi_xport_pkg::cmd_t plat_cmd;
  scmi_xport_pkg::used_t used, evused;
  scmi_xport_pkg::evbuf_t evbuf;
  int bad_count = 0, n_compared = 0, cyc = 0;
  wire [2:0] rdy = {evt_ready, result_ready, cmd_ready};
  scmi_xport #(.P2A_ATTR_MASK(MASK)) dut_u (.ref_clk, .rst_n, .can_p2a,
    .can_shm, .offered_features, .drv_features, .features_ok,
    .p2a_negotiated, .cmd_valid, .cmd_ready, .cmd, .plat_valid,
    .plat_ready, .plat_cmd, .result_valid, .result_ready, .result,
    .used_valid, .used_ready, .used, .evbuf_valid, .evbuf_ready, .evbuf,
    .evt_valid, .evt_ready, .evt, .evused_valid, .evused_ready, .evused,
    .notif_dropped);
  evq_drv_model drv_u (.ref_clk, .rst_n, .post, .post_id, .stall,
    .evbuf_valid, .evbuf_ready, .evbuf, .evused_ready);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      $display("BAD cycles exp below %0d got %0d", 5000, cyc);
      wrap_up();
    end
  end
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task cmp_flag(string n, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp_flag
  task cmp_cmd(string n, scmi_xport_pkg::cmd_t e, scmi_xport_pkg::cmd_t g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp_cmd
  task cmp_used(string n, scmi_xport_pkg::used_t e,
    scmi_xport_pkg::used_t g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp_used
  function automatic scmi_xport_pkg::used_t exp_used(
    scmi_xport_pkg::result_t r);
    scmi_xport_pkg::used_t u;
    u = '0;
    u.buf_id = r.buf_id;
    u.hdr = r.hdr;
    u.status = r.status;
    if (r.p2a_req && !neg)
      u.status = scmi_xport_pkg::STATUS_NOT_SUPPORTED;
    u.word = (r.attr_query && !neg) ? r.ret_word & ~MASK : r.ret_word;
    u.len = scmi_xport_pkg::HDR_BYTES + r.ret_len;
    if (u.status !== scmi_xport_pkg::STATUS_SUCCESS) begin
      u.len = scmi_xport_pkg::HDR_BYTES + scmi_xport_pkg::STATUS_BYTES;
      u.word = u.status;
    end
    return u;
  endfunction : exp_used
  function automatic scmi_xport_pkg::used_t exp_ev(logic [7:0] id,
    scmi_xport_pkg::evmsg_t m);
    scmi_xport_pkg::used_t u;
    u = exp_used({id, m.hdr, m.status, m.payload_len, m.word, 2'h0});
    u.qidx = scmi_xport_pkg::QIDX_EVT;
    return u;
  endfunction : exp_ev
  task hs(int k);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rdy[k] !== 1'b1 && n < 40);
    if (rdy[k] !== 1'b1) begin
      bad_count++;
      $display("BAD ready%0d exp 1 got %b", k, rdy[k]);
      wrap_up();
    end
    @(posedge ref_clk);
  endtask : hs
  task send_cmd(scmi_xport_pkg::cmd_t c, bit last);
    cmd_valid <= 1'b1;
    cmd <= c;
    hs(0);
    if (last) begin
      cmd_valid <= 1'b0;
      cmd <= ~c;
    end
  endtask : send_cmd
  task send_res(scmi_xport_pkg::result_t r, bit last);
    result_valid <= 1'b1;
    result <= r;
    hs(1);
    if (last) begin
      result_valid <= 1'b0;
      result <= ~r;
    end
  endtask : send_res
  task send_evt(scmi_xport_pkg::evmsg_t e);
    evt_valid <= 1'b1;
    evt <= e;
    hs(2);
    evt_valid <= 1'b0;
    evt <= ~e;
  endtask : send_evt
  task take_used(scmi_xport_pkg::used_t e, bit last);
    used_ready <= 1'b1;
    do @(negedge ref_clk); while (used_valid !== 1'b1);
    cmp_used("used", e, used);
    @(posedge ref_clk);
    if (last) used_ready <= 1'b0;
  endtask : take_used
  task take_ev(scmi_xport_pkg::used_t e);
    do @(negedge ref_clk); while ((evused_valid & evused_ready) !== 1'b1);
    cmp_used("evused", e, evused);
    @(posedge ref_clk);
  endtask : take_ev
  task chk_drop(logic e);
    logic s;
    s = 1'b0;
    repeat (2) begin
      @(negedge ref_clk);
      s = s | notif_dropped;
    end
    cmp_flag("dropped", e, s);
    @(posedge ref_clk);
  endtask : chk_drop
  task post_buf(logic [7:0] id);
    post <= 1'b1;
    post_id <= id;
    @(posedge ref_clk);
    post <= 1'b0;
  endtask : post_buf
  task t_feat;
    for (int i = 0; i < 4; i++) begin
      {can_shm, can_p2a} <= i[1:0];
      @(posedge ref_clk);
      @(negedge ref_clk);
      cmp_flag("offer_p2a", i[0], offered_features[0]);
      cmp_flag("offer_shm", i[1], offered_features[1]);
      @(posedge ref_clk);
    end
    $display("t_feat done");
  endtask : t_feat
  task t_cmd;
    scmi_xport_pkg::cmd_t c [2];
    c[0] = {8'h11, 32'h00010203, 12'h004};
    c[1] = {8'h12, 32'hA0B0C0D0, 12'h000};
    fork
      begin
        send_cmd(c[0], 1'b0);
        send_cmd(c[1], 1'b1);
      end
      for (int k = 0; k < 2; k++) begin
        do @(negedge ref_clk); while (plat_valid !== 1'b1);
        cmp_cmd("plat_cmd", c[k], plat_cmd);
        if (k == 0) cmp_flag("cmd_ready", 1'b0, cmd_ready);
        @(posedge ref_clk);
        plat_ready <= 1'b1;
        @(posedge ref_clk);
        plat_ready <= 1'b0;
      end
    join
    $display("t_cmd done");
  endtask : t_cmd
  task t_res;
    scmi_xport_pkg::result_t r [4];
    r[0] = {8'h05, 32'h00000101, 32'h0, 12'h00C, 32'h12345678, 2'h0};
    r[1] = {8'h02, 32'h00000202, 32'h3, 12'h020, 32'h9ABCDEF0, 2'h0};
    r[2] = {8'h07, 32'h00000303, 32'h0, 12'h004, 32'h00000000, 2'h2};
    r[3] = {8'h01, 32'h00000404, 32'h0, 12'h008, 32'hA5A50F0F, 2'h1};
    send_res(r[0], 1'b0);
    send_res(r[1], 1'b1);
    @(negedge ref_clk);
    cmp_flag("result_ready", 1'b0, result_ready);
    @(posedge ref_clk);
    take_used(exp_used(r[0]), 1'b0);
    take_used(exp_used(r[1]), 1'b0);
    for (int k = 2; k < 4; k++) begin
      send_res(r[k], 1'b1);
      take_used(exp_used(r[k]), k == 3);
    end
    $display("t_res done");
  endtask : t_res
  task t_neg(logic [1:0] f);
    drv_features <= f;
    features_ok <= 1'b1;
    @(posedge ref_clk);
    features_ok <= 1'b0;
    @(negedge ref_clk);
    cmp_flag("negotiated", f[0], p2a_negotiated);
    neg = f[0];
    @(posedge ref_clk);
    $display("t_neg done");
  endtask : t_neg
  task t_evt_off;
    post_buf(8'h21);
    @(negedge ref_clk);
    cmp_flag("evbuf_ready", 1'b0, evbuf_ready);
    @(posedge ref_clk);
    send_evt({1'b0, 32'h00000A0A, 32'h0, 12'h004, 32'h00000001});
    chk_drop(1'b1);
    $display("t_evt_off done");
  endtask : t_evt_off
  task t_evt_on;
    scmi_xport_pkg::evmsg_t d;
    send_evt({1'b0, 32'h00000B0B, 32'h0, 12'h008, 32'h00000002});
    chk_drop(1'b1);
    stall <= 1'b1;
    d = {1'b1, 32'h00001111, 32'h00000005, 12'h010, 32'h55AA55AA};
    send_evt(d);
    chk_drop(1'b0);
    @(negedge ref_clk);
    cmp_flag("evused_valid", 1'b1, evused_valid);
    @(posedge ref_clk);
    stall <= 1'b0;
    take_ev(exp_ev(8'h21, d));
    send_evt({1'b0, 32'h00000C0C, 32'h0, 12'h004, 32'h00000003});
    chk_drop(1'b1);
    d = {1'b1, 32'h00002222, 32'h0, 12'h004, 32'h0BADF00D};
    fork
      send_evt(d);
      begin
        repeat (2) @(negedge ref_clk);
        cmp_flag("evt_ready", 1'b0, evt_ready);
        @(posedge ref_clk);
        post_buf(8'h22);
      end
    join
    take_ev(exp_ev(8'h22, d));
    post_buf(8'h23);
    stall <= 1'b1;
    d = {1'b0, 32'h00003333, 32'h0, 12'h004, 32'h00000004};
    repeat (2) @(posedge ref_clk);
    send_evt(d);
    chk_drop(1'b0);
    stall <= 1'b0;
    take_ev(exp_ev(8'h23, d));
    $display("t_evt_on done");
  endtask : t_evt_on
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    cmp_flag("neg_rst", 1'b0, p2a_negotiated);
    @(posedge ref_clk);
    t_feat();
    t_cmd();
    t_res();
    t_evt_off();
    t_neg(2'h2);
    t_neg(2'h3);
    t_res();
    t_evt_on();
    wrap_up();
  end
endmodule : scmi_xport_tb
`default_nettype wire
